// ### pcgp_pad_model.sv
// Pad load model: resolves each pad from the port's drive, its pulls and an outside source
`timescale 1ns/1ns
module pcgp_pad_model (
	// Clock
	input  wire logic       ref_clk,
	// Port side
	input  wire logic [4:0] gpioOut,
	input  wire logic [4:0] gpioOe,
	input  wire logic [4:0] gpioPullUp,
	input  wire logic [4:0] gpioPullDown,
	// Outside source
	input  wire logic [4:0] extLevel,
	input  wire logic [4:0] extEn,
	// Resolved pads
	output logic      [4:0] padLevel
);
	// A floating pad keeps changing, so a settled guess never passes for a level
	logic [4:0] floatPat = 5'h15;
	always @(posedge ref_clk) begin
		floatPat <= ~floatPat;
	end
	// Port drive wins over the outside source; pulls only act on an undriven pad
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			if (gpioOe[i] === 1'b1) begin
				padLevel[i] = gpioOut[i];
			end else if (extEn[i]) begin
				padLevel[i] = extLevel[i];
			end else if (gpioPullUp[i] === 1'b1) begin
				padLevel[i] = 1'b1;
			end else if (gpioPullDown[i] === 1'b1) begin
				padLevel[i] = 1'b0;
			end else begin
				padLevel[i] = floatPat[i];
			end
		end
	end
endmodule

// ### pcgp_pin_if.sv
// Carrier between the port controller, sampler and PWM generator
`timescale 1ns/1ns
interface pcgp_pin_if;
	logic [4:0] level;
	logic [4:0] fall;
	logic [4:0] rise;
	logic [4:0] clr;
	logic [6:0] duty [5];
	logic [4:0] active;
	modport sampler (output level, output fall, output rise, input clr);
	modport pwm (input duty, output active);
	modport ctrl (input level, input fall, input rise, output clr,
		output duty, input active);
endinterface

// ### pcgp_pkg.sv
// Constants shared by the packet configured GPIO and PWM port
// ------------------------------------------------------------
// Summary of operation
// - Five pins, index 0-4; others select nothing
// - Level: 0 low, 1-99 PWM, 100 high
// - Sample every pin at 32 Hz always
// - Remember rising and falling edges between queries
// - Periodic sampling debounces the inputs
// - Two bytes set level; three also configure
// - Drive mode: eight codes, seven pad behaviours; reserved code 6 floats like input-only
// - Function bit: user control or shared function
// - Upper function byte nibble always reads zero
// - Configure answers type 0x62, no payload
// - Reply: index, state, level, function byte
// - State byte: level, falling, rising, reserved
// - Reported level is the sampled pin
// - Reply level is the requested value
// - Sampling independent of queries; short pulses missed
// - Store command saves configuration, restored at power-up
// ------------------------------------------------------------
package pcgp_pkg;
	localparam int       NUM_PINS     = 5;
	localparam int       CLK_HZ       = 250_000_000;
	localparam int       SAMPLE_HZ    = 32;
	localparam int       PWM_HZ       = 100;
	localparam int       PWM_STEPS    = 100;
	localparam int       SAMPLE_CYC   = CLK_HZ / SAMPLE_HZ;
	localparam int       PWM_STEP_CYC = CLK_HZ / (PWM_HZ * PWM_STEPS);
	localparam int       CFG_W        = 4;
	localparam int       BOOT_W       = NUM_PINS * (7 + CFG_W);
	// Register offsets
	localparam logic [7:0] REG_CMD      = 8'h00;
	localparam logic [7:0] REG_CMD_DATA = 8'h04;
	localparam logic [7:0] REG_RSP      = 8'h08;
	localparam logic [7:0] REG_RSP_DATA = 8'h0C;
	localparam logic [7:0] REG_LEVELS   = 8'h10;
	// Packet types
	localparam logic [7:0] CMD_STORE    = 8'h04;
	localparam logic [7:0] CMD_SET      = 8'h22;
	localparam logic [7:0] CMD_QUERY    = 8'h23;
	localparam logic [7:0] ACK_FLAG     = 8'h40;
	localparam logic [7:0] ERR_FLAG     = 8'hC0;
	localparam logic [7:0] LEVEL_MAX    = 8'h64;
	localparam logic [7:0] LEN_SHORT    = 8'h02;
	localparam logic [7:0] LEN_LONG     = 8'h03;
	localparam logic [7:0] LEN_ONE      = 8'h01;
	localparam logic [7:0] LEN_REPLY    = 8'h04;
	localparam logic [7:0] PIN_LIMIT    = 8'h05;
	// Function/drive layout
	localparam int         FUNC_BIT     = 3;
	localparam logic [3:0] CFG_RESET    = 4'h2;
	localparam logic [6:0] LEVEL_RESET  = 7'h00;
	typedef enum logic [2:0] {
		DM_UP_PD    = 3'b000,
		DM_FAST     = 3'b001,
		DM_HIZ      = 3'b010,
		DM_PU_DOWN  = 3'b011,
		DM_SUP_HIZ  = 3'b100,
		DM_SLOW     = 3'b101,
		DM_RSVD     = 3'b110,
		DM_HIZ_SDN  = 3'b111
	} pcgp_drive_e;
endpackage

// ### pcgp_port.sv
// Packet configured five-pin GPIO and PWM port with APB access
`timescale 1ns/1ns
module pcgp_port #(
	parameter int SAMPLE_CYC = pcgp_pkg::SAMPLE_CYC,
	parameter int STEP_CYC   = pcgp_pkg::PWM_STEP_CYC
) (
	// Clock and reset
	input  wire logic                        ref_clk,
	input  wire logic                        rst,
	// APB slave
	input  wire logic [7:0]                  paddr,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	// Pads
	input  wire logic [4:0]                  gpioIn,
	output logic      [4:0]                  gpioOut,
	output logic      [4:0]                  gpioOe,
	output logic      [4:0]                  gpioPullUp,
	output logic      [4:0]                  gpioPullDown,
	output logic      [4:0]                  gpioSlow,
	// Shared pin functions
	input  wire logic [4:0]                  sharedOut,
	// Boot state storage
	input  wire logic [pcgp_pkg::BOOT_W-1:0] bootImageIn,
	output logic      [pcgp_pkg::BOOT_W-1:0] bootImage,
	output logic                             bootSave
);
	// ------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------
	pcgp_pin_if pins ();

	pcgp_sampler #(
		.SAMPLE_CYC (SAMPLE_CYC)
	) u_sampler (
		.ref_clk (ref_clk),
		.rst     (rst),
		.gpioIn  (gpioIn),
		.pins    (pins.sampler)
	);

	pcgp_pwm #(
		.STEP_CYC (STEP_CYC)
	) u_pwm (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pins    (pins.pwm)
	);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [6:0]  level [5];
	logic [6:0]  next_level [5];
	logic [3:0]  cfg [5];
	logic [3:0]  next_cfg [5];
	logic [23:0] cmdData, next_cmdData;
	logic [15:0] cmdLast, next_cmdLast;
	logic [7:0]  rspType, next_rspType;
	logic [7:0]  rspLen, next_rspLen;
	logic [31:0] rspData, next_rspData;
	logic [31:0] next_prdata;
	logic        next_pslverr;
	logic [pcgp_pkg::BOOT_W-1:0] next_bootImage;
	logic        next_bootSave;
	logic        restorePending;
	logic [4:0]  clr;

	logic        setupPh, accessPh, wrCmd, wrData, mapped;
	logic [7:0]  cmdType, cmdLen, cmdIdx, cmdLvl, cmdFd;
	logic [2:0]  pin;
	logic        idxOk, setOk, queryOk;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	always_comb begin
		setupPh = psel && !penable;
		accessPh = psel && penable;
		mapped = (paddr == pcgp_pkg::REG_CMD) || (paddr == pcgp_pkg::REG_CMD_DATA)
			|| (paddr == pcgp_pkg::REG_RSP) || (paddr == pcgp_pkg::REG_RSP_DATA)
			|| (paddr == pcgp_pkg::REG_LEVELS);
		wrCmd = accessPh && pwrite && (paddr == pcgp_pkg::REG_CMD);
		wrData = accessPh && pwrite && (paddr == pcgp_pkg::REG_CMD_DATA);
		cmdType = pwdata[7:0];
		cmdLen = pwdata[15:8];
		cmdIdx = cmdData[7:0];
		cmdLvl = cmdData[15:8];
		cmdFd = cmdData[23:16];
		pin = cmdIdx[2:0];
		idxOk = (cmdIdx < pcgp_pkg::PIN_LIMIT);
		setOk = idxOk && (cmdLvl <= pcgp_pkg::LEVEL_MAX)
			&& ((cmdLen == pcgp_pkg::LEN_SHORT) || (cmdLen == pcgp_pkg::LEN_LONG));
		queryOk = idxOk && (cmdLen == pcgp_pkg::LEN_ONE);
	end

	// Read data is captured in the setup cycle so that it leaves a flop
	always_comb begin
		next_prdata = prdata;
		next_pslverr = 1'b0;
		if (setupPh) begin
			next_pslverr = !mapped;
			case (paddr)
				pcgp_pkg::REG_CMD:      next_prdata = {16'h0000, cmdLast};
				pcgp_pkg::REG_CMD_DATA: next_prdata = {8'h00, cmdData};
				pcgp_pkg::REG_RSP:      next_prdata = {16'h0000, rspLen, rspType};
				pcgp_pkg::REG_RSP_DATA: next_prdata = rspData;
				pcgp_pkg::REG_LEVELS:   next_prdata = {27'h000_0000, pins.level};
				default:                next_prdata = 32'h0000_0000;
			endcase
		end
	end

	assign pready = 1'b1;

	// ------------------------------------------------------------
	// Command execution
	// ------------------------------------------------------------
	always_comb begin
		next_cmdData = wrData ? pwdata[23:0] : cmdData;
		next_cmdLast = wrCmd ? pwdata[15:0] : cmdLast;
		next_rspType = rspType;
		next_rspLen = rspLen;
		next_rspData = rspData;
		next_bootSave = 1'b0;
		next_bootImage = bootImage;
		clr = '0;
		for (int i = 0; i < pcgp_pkg::NUM_PINS; i++) begin
			next_level[i] = level[i];
			next_cfg[i] = cfg[i];
		end
		if (restorePending) begin
			// Power-up restore of the stored configuration
			for (int i = 0; i < pcgp_pkg::NUM_PINS; i++) begin
				next_level[i] = bootImageIn[i*11 +: 7];
				next_cfg[i] = bootImageIn[i*11+7 +: 4];
			end
		end else if (wrCmd) begin
			next_rspLen = 8'h00;
			next_rspData = 32'h0000_0000;
			case (cmdType)
				pcgp_pkg::CMD_SET: begin
					if (setOk) begin
						next_level[pin] = cmdLvl[6:0];
						if (cmdLen == pcgp_pkg::LEN_LONG) begin
							// Reserved upper nibble is dropped, never stored
							next_cfg[pin] = cmdFd[3:0];
						end
						next_rspType = pcgp_pkg::ACK_FLAG | cmdType;
					end else begin
						next_rspType = pcgp_pkg::ERR_FLAG | cmdType;
					end
				end
				pcgp_pkg::CMD_QUERY: begin
					if (queryOk) begin
						next_rspType = cmdType;
						next_rspLen = pcgp_pkg::LEN_REPLY;
						// State byte keeps its reserved bit so level lands in byte 2
						next_rspData = {4'h0, cfg[pin], 1'b0, level[pin], 4'h0, 1'b0,
							pins.rise[pin], pins.fall[pin], pins.level[pin],
							cmdIdx};
						clr[pin] = 1'b1;
					end else begin
						next_rspType = pcgp_pkg::ERR_FLAG | cmdType;
					end
				end
				pcgp_pkg::CMD_STORE: begin
					for (int i = 0; i < pcgp_pkg::NUM_PINS; i++) begin
						next_bootImage[i*11 +: 11] = {cfg[i], level[i]};
					end
					next_bootSave = 1'b1;
					next_rspType = pcgp_pkg::ACK_FLAG | cmdType;
				end
				default: begin
					next_rspType = pcgp_pkg::ERR_FLAG | cmdType;
				end
			endcase
		end
	end

	always_comb begin
		for (int i = 0; i < pcgp_pkg::NUM_PINS; i++) begin
			pins.duty[i] = level[i];
		end
		pins.clr = clr;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int i = 0; i < pcgp_pkg::NUM_PINS; i++) begin
				level[i] <= pcgp_pkg::LEVEL_RESET;
				cfg[i] <= pcgp_pkg::CFG_RESET;
			end
			cmdData <= '0;
			cmdLast <= '0;
			rspType <= '0;
			rspLen <= '0;
			rspData <= '0;
			prdata <= '0;
			pslverr <= 1'b0;
			bootImage <= '0;
			bootSave <= 1'b0;
			restorePending <= 1'b1;
		end else begin
			level <= next_level;
			cfg <= next_cfg;
			cmdData <= next_cmdData;
			cmdLast <= next_cmdLast;
			rspType <= next_rspType;
			rspLen <= next_rspLen;
			rspData <= next_rspData;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
			bootImage <= next_bootImage;
			bootSave <= next_bootSave;
			restorePending <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Pad drive decode
	// ------------------------------------------------------------
	logic [4:0] next_out, next_oe, next_pu, next_pd, next_slow, drvVal;

	for (genvar i = 0; i < pcgp_pkg::NUM_PINS; i++) begin : g_pad
		pcgp_pkg::pcgp_drive_e mode;
		// A pin left to its shared function follows that function's level
		assign drvVal[i] = cfg[i][pcgp_pkg::FUNC_BIT] ? pins.active[i] : sharedOut[i];
		assign mode = pcgp_pkg::pcgp_drive_e'(cfg[i][2:0]);
		always_comb begin
			next_out[i] = drvVal[i];
			next_oe[i] = 1'b0;
			next_pu[i] = 1'b0;
			next_pd[i] = 1'b0;
			next_slow[i] = 1'b0;
			case (mode)
				pcgp_pkg::DM_UP_PD: begin
					next_oe[i] = drvVal[i];
					next_pd[i] = !drvVal[i];
				end
				pcgp_pkg::DM_FAST: begin
					next_oe[i] = 1'b1;
				end
				pcgp_pkg::DM_PU_DOWN: begin
					next_oe[i] = !drvVal[i];
					next_pu[i] = drvVal[i];
				end
				pcgp_pkg::DM_SUP_HIZ: begin
					next_oe[i] = drvVal[i];
					next_slow[i] = 1'b1;
				end
				pcgp_pkg::DM_SLOW: begin
					next_oe[i] = 1'b1;
					next_slow[i] = 1'b1;
				end
				pcgp_pkg::DM_HIZ_SDN: begin
					next_oe[i] = !drvVal[i];
					next_slow[i] = 1'b1;
				end
				// Input-only and reserved codes leave the pad floating
				default: begin
					next_oe[i] = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			gpioOut <= '0;
			gpioOe <= '0;
			gpioPullUp <= '0;
			gpioPullDown <= '0;
			gpioSlow <= '0;
		end else begin
			gpioOut <= next_out;
			gpioOe <= next_oe;
			gpioPullUp <= next_pu;
			gpioPullDown <= next_pd;
			gpioSlow <= next_slow;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_set_ok;
		wrCmd && !restorePending && (cmdType == pcgp_pkg::CMD_SET) && setOk;
	endsequence

	sequence s_query_ok;
		wrCmd && !restorePending && (cmdType == pcgp_pkg::CMD_QUERY) && queryOk;
	endsequence

	a_cfg_ack: assert property (s_set_ok |=> (rspType == 8'h62) && (rspLen == 8'h00))
		else $error("configure not acknowledged with 0x62");
	a_query_reply: assert property (s_query_ok |=> (rspLen == 8'h04)
		&& (rspData[7:0] == $past(cmdIdx)))
		else $error("query reply malformed");
	a_fd_upper: assert property (s_query_ok |=> (rspData[31:28] == 4'h0)
		&& (rspData[15:11] == 5'h00))
		else $error("reserved reply bits not zero");
	a_bad_index: assert property (wrCmd && !restorePending
		&& (cmdType == pcgp_pkg::CMD_QUERY) && (cmdIdx >= 8'h05)
		|=> rspType == 8'hE3)
		else $error("reserved index not refused");
	a_short_set: assert property (s_set_ok ##0 (cmdLen == 8'h02)
		|=> cfg[$past(pin)] == $past(cfg[pin]))
		else $error("two-byte configure changed the drive");
	a_query_clear: assert property (s_query_ok |-> clr[pin])
		else $error("query did not clear edge flags");
	a_level_range: assert property (level[0] <= 7'd100)
		else $error("stored level above 100");
	a_hiz_pad: assert property (cfg[0][2:0] == 3'b010 |=> !gpioOe[0])
		else $error("input mode drives the pad");
	a_strong_pad: assert property ((cfg[0] == 4'b1001) && pins.active[0]
		|=> gpioOe[0] && gpioOut[0])
		else $error("strong drive mode not driving high");
endmodule

// ### pcgp_port_test.sv
// Self-checking bench for the packet configured GPIO and PWM port
`timescale 1ns/1ns
module pcgp_port_test;
	// ----------------------------------------------------------
	// Signals
	// ----------------------------------------------------------
	localparam int SCYC   = 8;
	localparam int STEP   = 2;
	localparam int SETTLE = 4 * SCYC;
	logic                        ref_clk   = 1'b0;
	logic                        rst       = 1'b1;
	logic [7:0]                  paddr     = 8'h00;
	logic                        psel      = 1'b0;
	logic                        penable   = 1'b0;
	logic                        pwrite    = 1'b0;
	logic [31:0]                 pwdata    = 32'h0000_0000;
	logic [4:0]                  sharedOut = 5'h00;
	logic [4:0]                  extLevel  = 5'h00;
	logic [4:0]                  extEn     = 5'h1F;
	logic [31:0]                 rnd       = 32'h0000_07da;
	logic [31:0]                 prdata, rd, rs;
	logic                        pready, pslverr, er, bootSave;
	logic [4:0]                  gpioIn, gpioOut, gpioOe, gpioPullUp, gpioPullDown, gpioSlow;
	logic [pcgp_pkg::BOOT_W-1:0] bootImageIn, bootImage;
	int                          nFail = 0;
	int                          nTests = 0;
	int                          nSave = 0;

	always #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (bootSave === 1'b1) nSave <= nSave + 1;
	end

	pcgp_port #(.SAMPLE_CYC(SCYC), .STEP_CYC(STEP)) dut (
		.ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe),
		.gpioPullUp(gpioPullUp), .gpioPullDown(gpioPullDown), .gpioSlow(gpioSlow),
		.sharedOut(sharedOut), .bootImageIn(bootImageIn), .bootImage(bootImage),
		.bootSave(bootSave));
	pcgp_pad_model pad (
		.ref_clk(ref_clk), .gpioOut(gpioOut), .gpioOe(gpioOe), .gpioPullUp(gpioPullUp),
		.gpioPullDown(gpioPullDown), .extLevel(extLevel), .extEn(extEn), .padLevel(gpioIn));

	// ----------------------------------------------------------
	// Tasks and functions
	// ----------------------------------------------------------
	task automatic endOfTest();
		$display("checks %0d failures %0d", nTests, nFail);
		if (nFail == 0 && nTests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		nTests++;
		if (got !== exp) begin
			nFail++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		xs = y ^ (y << 5);
	endfunction

	// Expected pad controls {oe, pull up, pull down, slow, out} for a drive mode and value
	function automatic logic [4:0] padExp(input logic [2:0] dm, input logic v);
		case (dm)
			3'b000:  padExp = {v, 1'b0, ~v, 1'b0, v};
			3'b001:  padExp = {1'b1, 3'b000, v};
			3'b011:  padExp = {~v, v, 2'b00, v};
			3'b100:  padExp = {v, 2'b00, 1'b1, v};
			3'b101:  padExp = {1'b1, 2'b00, 1'b1, v};
			3'b111:  padExp = {~v, 2'b00, 1'b1, v};
			default: padExp = {4'b0000, v};
		endcase
	endfunction

	// Request held until pready is seen high at a rising edge; the reply is taken at that edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		int i;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge ref_clk);
			if (pready === 1'b1) begin
				r = prdata;
				e = pslverr;
				break;
			end
		end
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 16) begin
			nFail++;
			endOfTest();
		end
	endtask

	task automatic cmd(input logic [7:0] t, input logic [7:0] len, input logic [23:0] d);
		apb(1'b1, pcgp_pkg::REG_CMD_DATA, {8'h00, d}, rd, er);
		apb(1'b1, pcgp_pkg::REG_CMD, {16'h0000, len, t}, rd, er);
		apb(1'b0, pcgp_pkg::REG_RSP, 32'h0000_0000, rs, er);
		apb(1'b0, pcgp_pkg::REG_RSP_DATA, 32'h0000_0000, rd, er);
	endtask

	task automatic setPin(input logic [7:0] idx, input logic [7:0] lvl, input logic [7:0] cfg,
			input logic three, input logic [7:0] expType);
		cmd(pcgp_pkg::CMD_SET, three ? pcgp_pkg::LEN_LONG : pcgp_pkg::LEN_SHORT, {cfg, lvl, idx});
		check("set reply", {24'h0, expType}, rs & 32'h0000_FFFF);
	endtask

	task automatic query(input logic [7:0] idx, input logic [31:0] exp);
		cmd(pcgp_pkg::CMD_QUERY, pcgp_pkg::LEN_ONE, {16'h0000, idx});
		if (idx < 8'd5) begin
			check("query reply", 32'h0000_0423, rs & 32'h0000_FFFF);
			check("query data", exp, rd);
		end else begin
			check("query reply", 32'h0000_00E3, rs & 32'h0000_FFFF);
		end
	endtask

	// ----------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------
	initial begin
		int         cnt;
		logic [7:0] lvl;
		logic [7:0] lvls [4];
		lvls = '{8'h00, 8'h64, 8'h01, 8'h63};
		for (int i = 0; i < 5; i++) bootImageIn[i*11+:11] = {4'h2, 7'(i * 10)};
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		query(8'd4, 32'h0228_0004);
		for (int m = 0; m < 8; m++) begin
			for (int v = 0; v < 2; v++) begin
				setPin(8'd0, v ? 8'h64 : 8'h00, {5'b00001, 3'(m)}, 1'b1, 8'h62);
				repeat (3) @(negedge ref_clk);
				check("pad 0", {27'h0, padExp(3'(m), v[0])}, {27'h0, gpioOe[0], gpioPullUp[0],
					gpioPullDown[0], gpioSlow[0], gpioOut[0]});
			end
		end
		query(8'd0, 32'h0F64_0600);
		setPin(8'd0, 8'h00, 8'h00, 1'b0, 8'h62);
		query(8'd0, 32'h0F00_0000);
		setPin(8'd5, 8'h00, 8'h00, 1'b0, 8'hE2);
		setPin(8'hFF, 8'h00, 8'h00, 1'b0, 8'hE2);
		setPin(8'd0, 8'h65, 8'h00, 1'b0, 8'hE2);
		query(8'd5, 32'h0000_0000);
		query(8'd0, 32'h0F00_0000);
		cmd(8'h55, 8'h00, 24'h0);
		check("unknown reply", 32'h0000_00D5, rs & 32'h0000_FFFF);
		apb(1'b0, 8'h20, 32'h0000_0000, rd, er);
		check("unmapped err", 32'h0000_0001, {31'h0, er});
		check("unmapped data", 32'h0000_0000, rd);
		setPin(8'd1, 8'h00, 8'h0A, 1'b1, 8'h62);
		query(8'd1, 32'h0A00_0001);
		extLevel[1] <= 1'b1;
		repeat (SETTLE) @(posedge ref_clk);
		extLevel[1] <= 1'b0;
		repeat (SETTLE) @(posedge ref_clk);
		query(8'd1, 32'h0A00_0601);
		query(8'd1, 32'h0A00_0001);
		extLevel[1] <= 1'b1;
		repeat (SETTLE) @(posedge ref_clk);
		query(8'd1, 32'h0A00_0501);
		setPin(8'd3, 8'h64, 8'h0B, 1'b1, 8'h62);
		extEn[3] <= 1'b0;
		repeat (SETTLE) @(posedge ref_clk);
		apb(1'b0, pcgp_pkg::REG_LEVELS, 32'h0000_0000, rd, er);
		check("level pin 3", 32'h0000_0001, {31'h0, rd[3]});
		extEn[3] <= 1'b1;
		repeat (SETTLE) @(posedge ref_clk);
		apb(1'b0, pcgp_pkg::REG_LEVELS, 32'h0000_0000, rd, er);
		check("level pin 3", 32'h0000_0000, {31'h0, rd[3]});
		query(8'd3, 32'h0B64_0603);
		for (int k = 0; k < 7; k++) begin
			rnd = xs(rnd);
			lvl = (k < 4) ? lvls[k] : 8'(rnd % 32'd99 + 32'd1);
			setPin(8'd2, lvl, 8'h09, 1'b1, 8'h62);
			repeat (100 * STEP + 4) @(negedge ref_clk);
			cnt = 0;
			repeat (100 * STEP) begin
				@(negedge ref_clk);
				if (gpioOut[2] === 1'b1) cnt++;
			end
			check("pwm high cycles", 32'(lvl) * STEP, 32'(cnt));
		end
		setPin(8'd4, 8'h00, 8'h07, 1'b1, 8'h62);
		for (int k = 0; k < 4; k++) begin
			rnd = xs(rnd);
			@(posedge ref_clk);
			sharedOut <= rnd[4:0] ^ {k[0], 4'h0};
			repeat (3) @(negedge ref_clk);
			check("shared pin", {29'h0, ~sharedOut[4], sharedOut[4], 1'b1},
				{29'h0, gpioOe[4], gpioOut[4], gpioSlow[4]});
		end
		cmd(pcgp_pkg::CMD_STORE, 8'h00, 24'h0);
		repeat (2) @(negedge ref_clk);
		check("store reply", 32'h0000_0044, rs & 32'h0000_FFFF);
		check("image pin 2", {21'h0, 4'h9, lvl[6:0]}, {21'h0, bootImage[22+:11]});
		check("save pulses", 32'h0000_0001, 32'(nSave));
		endOfTest();
	end

	initial begin
		repeat (100000) @(posedge ref_clk);
		nFail++;
		endOfTest();
	end
endmodule

// ### pcgp_pwm.sv
// Shared 100-step PWM timebase with one comparator per pin
`timescale 1ns/1ns
module pcgp_pwm #(
	parameter int STEP_CYC = pcgp_pkg::PWM_STEP_CYC
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// Carrier
	pcgp_pin_if.pwm   pins
);
	localparam int CW = $clog2(STEP_CYC + 1);
	logic [CW-1:0] divCnt, next_divCnt;
	logic [6:0]    phase, next_phase;
	logic [4:0]    active, next_active;
	logic          stepEnd;

	always_comb begin
		stepEnd = (divCnt == CW'(STEP_CYC - 1));
		next_divCnt = stepEnd ? '0 : divCnt + 1'b1;
		next_phase = phase;
		if (stepEnd) begin
			next_phase = (phase == 7'(pcgp_pkg::PWM_STEPS - 1)) ? '0 : phase + 1'b1;
		end
	end

	for (genvar i = 0; i < pcgp_pkg::NUM_PINS; i++) begin : g_cmp
		// Level 0 never active, 100 always active
		assign next_active[i] = (next_phase < pins.duty[i]);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			divCnt <= '0;
			phase <= '0;
			active <= '0;
		end else begin
			divCnt <= next_divCnt;
			phase <= next_phase;
			active <= next_active;
		end
	end

	assign pins.active = active;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_duty_full: assert property ((pins.duty[0] == 7'd100) [*2] |-> active[0])
		else $error("full level not held high");
	a_duty_zero: assert property ((pins.duty[0] == 7'd0) [*2] |-> !active[0])
		else $error("zero level not held low");
endmodule

// ### pcgp_sampler.sv
// Periodic input sampler with sticky edge flags
`timescale 1ns/1ns
module pcgp_sampler #(
	parameter int SAMPLE_CYC = pcgp_pkg::SAMPLE_CYC
) (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// Pads
	input  wire logic [4:0] gpioIn,
	// Carrier
	pcgp_pin_if.sampler     pins
);
	localparam int CW = $clog2(SAMPLE_CYC + 1);
	logic [CW-1:0] tickCnt, next_tickCnt;
	logic [4:0]    sync1, sync2;
	logic [4:0]    level, next_level, fall, next_fall, rise, next_rise;
	logic          tick;
	logic [4:0]    newRise, newFall;

	always_comb begin
		tick = (tickCnt == CW'(SAMPLE_CYC - 1));
		next_tickCnt = tick ? '0 : tickCnt + 1'b1;
		// Only the sample instant sees the pad, which is the debounce
		next_level = tick ? sync2 : level;
		newRise = tick ? (sync2 & ~level) : '0;
		newFall = tick ? (~sync2 & level) : '0;
		// A new edge wins over the clear of the same cycle
		next_rise = (rise & ~pins.clr) | newRise;
		next_fall = (fall & ~pins.clr) | newFall;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tickCnt <= '0;
			sync1 <= '0;
			sync2 <= '0;
			level <= '0;
			rise <= '0;
			fall <= '0;
		end else begin
			tickCnt <= next_tickCnt;
			sync1 <= gpioIn;
			sync2 <= sync1;
			level <= next_level;
			rise <= next_rise;
			fall <= next_fall;
		end
	end

	assign pins.level = level;
	assign pins.rise = rise;
	assign pins.fall = fall;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_rise_at_clear(int i);
		tick && sync2[i] && !level[i] && pins.clr[i];
	endsequence

	a_sample_hold: assert property (!tick |=> $stable(level))
		else $error("sampled level moved between sample instants");
	a_edge_kept: assert property (s_rise_at_clear(0) |=> rise[0])
		else $error("edge lost on a simultaneous clear");
endmodule
